// ==== virq_pkg.sv ====
// Purpose: Shared constants for the vectored interrupt and wake controller.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package virq_pkg;
    // ----------------
    // Sizes
    // ----------------
    localparam int unsigned NUM_LINES  = 32;
    localparam int unsigned PORT_PINS  = 8;

    // ----------------
    // Register offsets
    // ----------------
    localparam logic [11:0] OFS_ENABLE   = 12'h000;
    localparam logic [11:0] OFS_PENDING  = 12'h004;
    localparam logic [11:0] OFS_ACTIVE   = 12'h008;
    localparam logic [11:0] OFS_STATUS   = 12'h00c;
    localparam logic [11:0] OFS_WAKE_EN  = 12'h010;
    localparam logic [11:0] OFS_PIN_EDGE = 12'h014;
    localparam logic [11:0] OFS_PIN_FLAG = 12'h018;
    localparam logic [11:0] OFS_WDOG_CTL = 12'h01c;
    localparam logic [11:0] OFS_WDOG_LIM = 12'h020;
    localparam logic [11:0] OFS_I2C_EN   = 12'h024;
    localparam logic [11:0] OFS_PRIO     = 12'h040;
    localparam logic [11:0] OFS_SEL      = 12'h060;
    localparam logic [11:0] OFS_VECT     = 12'h100;

    // ----------------
    // Field positions and reset values
    // ----------------
    localparam int unsigned WCTL_EN_BIT    = 0;
    localparam int unsigned WCTL_RESET_BIT = 1;
    localparam int unsigned WCTL_BIG_BIT   = 2;
    localparam int unsigned CMP_EDGE_LSB   = 16;
    localparam logic [31:0] RST_VECT      = 32'h0000_0000;
    localparam logic [31:0] RST_WDOG_LIM  = 32'h0000_ffff;

    // Edge select codes for pins and comparator.
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Power states.
    localparam logic [1:0] PWR_ACTIVE = 2'h0;
    localparam logic [1:0] PWR_SLEEP  = 2'h1;
    localparam logic [1:0] PWR_DEEP   = 2'h2;
    localparam logic [1:0] PWR_HIBER  = 2'h3;

    // Fixed source numbers on the selection bus.
    localparam logic [5:0] SRC_PORT0 = 6'h00;
    localparam logic [5:0] SRC_PORT1 = 6'h01;
    localparam logic [5:0] SRC_CMP   = 6'h02;
    localparam logic [5:0] SRC_WDOG  = 6'h03;
    localparam logic [5:0] SRC_I2C   = 6'h04;
    localparam int unsigned SRC_FABRIC = 32;

    // Core hand-shake state.
    typedef enum logic [1:0] {
        VIRQ_IDLE = 2'b01,
        VIRQ_REQ  = 2'b10
    } virq_hs_e;
endpackage

// ==== virq_ctrl.sv ====
// Purpose: Vectored nested interrupt controller with always-on wake logic.
// Assumes: Inputs synchronous to clk_i; core acks are one-cycle pulses.
// Notes:   Source bus: 0-1 port pins, 2 comparator, 3 watchdog, 4 serial
//          block, 32-63 programmable digital block fabric.
// Notes on behaviour
// - Thirty-two request lines, each with a two-bit priority, zero to three.
// - Each line has its own programmable vector address.
// - Selected active line presents its vector with the request to the core.
// - Each line is individually enabled; masked lines never request.
// - Simultaneous requests are resolved by priority, one winner forwarded.
// - Strictly higher priority pending preempts a running routine, nesting.
// - Wake logic stays running in Sleep, Deep Sleep and Hibernate.
// - Wake trigger asks power management to restore controller and core.
// - All sources reach the controller; only wake-capable ones reach wake logic.
// - Lines zero and one are port-pin lines, also routed to wake logic.
// - Each line's source is selectable from the routed source bus.
// - Programmable digital block signals can raise interrupts via routing.
// - Eight pins per port interrupt, sharing one vector; software finds pin.
// - Pin trigger is rising, falling or both edges.
// - Pin interrupt wakes from Sleep, Deep Sleep and Hibernate.
// - Comparator edge interrupt, configurable edges, wakes from all low states.
// - Watchdog resets or interrupts; one 16-bit or two 16 plus one 32-bit.
// - Two-wire serial block events raise an interrupt.
//
// Implementation choices: register access over APB and the register addresses.
module virq_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  port0_pins_i,
    input  wire logic [7:0]  port1_pins_i,
    input  wire logic        cmp_out_i,
    input  wire logic [10:0] i2c_events_i,
    input  wire logic [31:0] fabric_src_i,
    input  wire logic [1:0]  power_state_i,
    output logic             irq_req_o,
    output logic      [31:0] irq_vector_o,
    output logic      [4:0]  irq_line_o,
    input  wire logic        ack_enter_i,
    input  wire logic        ack_exit_i,
    output logic             wake_req_o,
    output logic             wdog_reset_o
);
    // ----------------
    // Register storage
    // ----------------
    logic [31:0] enable_q;
    logic [31:0] wake_en_q;
    logic [31:0] pin_edge_q;
    logic [31:0] wdog_ctl_q;
    logic [31:0] wdog_lim_q;
    logic [10:0] i2c_en_q;
    logic [1:0]  prio_q  [virq_pkg::NUM_LINES];
    logic [5:0]  sel_q   [virq_pkg::NUM_LINES];
    logic [31:0] vect_q  [virq_pkg::NUM_LINES];
    logic [31:0] pending_q;
    logic [31:0] active_q;
    logic [15:0] pin_flag_q;
    logic [7:0]  p0_prev_q;
    logic [7:0]  p1_prev_q;
    logic        cmp_prev_q;
    logic [15:0] wdog_a_q;
    logic [15:0] wdog_b_q;
    logic [31:0] wdog_c_q;
    logic        wdog_hit_q;
    virq_pkg::virq_hs_e hs_q;
    logic        wr_en;
    logic [63:0] src_bus;
    logic [31:0] line_lvl;
    logic [31:0] line_prev_q;
    logic [15:0] pin_hit;
    logic        cmp_hit;

    assign wr_en = psel_i & penable_i & pwrite_i;
    // Edge detector shared by pins and comparator.
    function automatic logic edge_hit(input logic [1:0] mode, input logic prev,
                                      input logic cur);
        edge_hit = ((mode == virq_pkg::EDGE_RISE || mode == virq_pkg::EDGE_BOTH)
                    && !prev && cur)
                 || ((mode == virq_pkg::EDGE_FALL || mode == virq_pkg::EDGE_BOTH)
                    && prev && !cur);
    endfunction
    // Table offset decode, used by reads and writes alike.
    function automatic logic in_table(input logic [11:0] a, input logic [11:0] base,
                                      input int unsigned n);
        in_table = (a >= base) && (a < base + 12'(n * 4));
    endfunction
    // ----------------
    // Peripheral sources
    // ----------------
    // Pin edges; all pins of a port fold onto the port's one line.
    for (genvar p = 0; p < virq_pkg::PORT_PINS; p++) begin : g_pins
        assign pin_hit[p] = edge_hit(pin_edge_q[2*p +: 2], p0_prev_q[p],
                                     port0_pins_i[p]);
        assign pin_hit[p+8] = edge_hit(pin_edge_q[2*p+16 +: 2], p1_prev_q[p],
                                       port1_pins_i[p]);
    end
    assign cmp_hit = edge_hit(wdog_ctl_q[virq_pkg::CMP_EDGE_LSB +: 2], cmp_prev_q,
                              cmp_out_i);
    // Per-pin sticky flags let software find which pin fired; write one clears.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_flag_q <= 16'h0000;
            p0_prev_q  <= 8'h00;
            p1_prev_q  <= 8'h00;
            cmp_prev_q <= 1'b0;
        end else begin
            p0_prev_q  <= port0_pins_i;
            p1_prev_q  <= port1_pins_i;
            cmp_prev_q <= cmp_out_i;
            // Set wins over clear so no edge is lost.
            if (wr_en && paddr_i == virq_pkg::OFS_PIN_FLAG) begin
                pin_flag_q <= (pin_flag_q & ~pwdata_i[15:0]) | pin_hit;
            end else begin
                pin_flag_q <= pin_flag_q | pin_hit;
            end
        end
    end
    // Watchdog counters; the small build uses only counter A.
    logic wdog_tick;
    assign wdog_tick = wdog_ctl_q[virq_pkg::WCTL_BIG_BIT]
                     ? (wdog_c_q == wdog_lim_q)
                     : (wdog_a_q == wdog_lim_q[15:0]);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wdog_a_q     <= 16'h0000;
            wdog_b_q     <= 16'h0000;
            wdog_c_q     <= 32'h0000_0000;
            wdog_hit_q   <= 1'b0;
            wdog_reset_o <= 1'b0;
        end else if (!wdog_ctl_q[virq_pkg::WCTL_EN_BIT]) begin
            wdog_a_q     <= 16'h0000;
            wdog_b_q     <= 16'h0000;
            wdog_c_q     <= 32'h0000_0000;
            wdog_hit_q   <= 1'b0;
            wdog_reset_o <= 1'b0;
        end else begin
            wdog_a_q   <= wdog_tick ? 16'h0000 : wdog_a_q + 16'h0001;
            // Counters B and C cascade from A in the large build.
            if (wdog_a_q == 16'hffff) begin
                wdog_b_q <= wdog_b_q + 16'h0001;
            end
            if (wdog_ctl_q[virq_pkg::WCTL_BIG_BIT] && wdog_b_q == 16'hffff
                && wdog_a_q == 16'hffff) begin
                wdog_c_q <= wdog_tick ? 32'h0000_0000 : wdog_c_q + 32'h0000_0001;
            end
            wdog_hit_q   <= wdog_tick & ~wdog_ctl_q[virq_pkg::WCTL_RESET_BIT];
            wdog_reset_o <= wdog_tick & wdog_ctl_q[virq_pkg::WCTL_RESET_BIT];
        end
    end
    // Source bus: fixed peripherals low, fabric signals high.
    always_comb begin
        src_bus = 64'h0;
        src_bus[virq_pkg::SRC_PORT0] = |pin_flag_q[7:0];
        src_bus[virq_pkg::SRC_PORT1] = |pin_flag_q[15:8];
        src_bus[virq_pkg::SRC_CMP]   = cmp_hit;
        src_bus[virq_pkg::SRC_WDOG]  = wdog_hit_q;
        src_bus[virq_pkg::SRC_I2C]   = |(i2c_events_i & i2c_en_q);
        src_bus[63:virq_pkg::SRC_FABRIC] = fabric_src_i;
    end
    // ----------------
    // Line selection, pending and arbitration
    // ----------------
    for (genvar l = 0; l < virq_pkg::NUM_LINES; l++) begin : g_lines
        assign line_lvl[l] = src_bus[sel_q[l]];
    end
    // Winner search: lowest priority number wins, lowest line breaks ties.
    logic [4:0] win_line;
    logic [1:0] win_prio;
    logic       win_ok;
    logic [2:0] run_prio;
    logic [31:0] cand;
    assign cand = pending_q & enable_q;
    always_comb begin
        win_line = 5'h00;
        win_prio = 2'h3;
        win_ok   = 1'b0;
        for (int i = virq_pkg::NUM_LINES - 1; i >= 0; i--) begin
            if (cand[i] && (!win_ok || prio_q[i] <= win_prio)) begin
                win_ok   = 1'b1;
                win_line = 5'(i);
                win_prio = prio_q[i];
            end
        end
        // Running level is the best priority among active routines; 4 means none.
        run_prio = 3'h4;
        for (int i = 0; i < virq_pkg::NUM_LINES; i++) begin
            if (active_q[i] && {1'b0, prio_q[i]} < run_prio) begin
                run_prio = {1'b0, prio_q[i]};
            end
        end
    end
    logic take;
    assign take = win_ok && ({1'b0, win_prio} < run_prio);
    // Pending: set on a rising level, cleared on entry ack; set wins.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_prev_q <= 32'h0;
            pending_q   <= 32'h0;
        end else begin
            line_prev_q <= line_lvl;
            for (int i = 0; i < virq_pkg::NUM_LINES; i++) begin
                if (line_lvl[i] && !line_prev_q[i]) begin
                    pending_q[i] <= 1'b1;
                end else if (ack_enter_i && hs_q == virq_pkg::VIRQ_REQ
                             && irq_line_o == 5'(i)) begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    end
    // Core hand-shake: request with vector until entry ack, exit ack retires.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hs_q         <= virq_pkg::VIRQ_IDLE;
            irq_req_o    <= 1'b0;
            irq_vector_o <= virq_pkg::RST_VECT;
            irq_line_o   <= 5'h00;
        end else begin
            case (hs_q)
                virq_pkg::VIRQ_IDLE: begin
                    if (take) begin
                        hs_q         <= virq_pkg::VIRQ_REQ;
                        irq_req_o    <= 1'b1;
                        irq_vector_o <= vect_q[win_line];
                        irq_line_o   <= win_line;
                    end
                end
                virq_pkg::VIRQ_REQ: begin
                    if (ack_enter_i) begin
                        hs_q      <= virq_pkg::VIRQ_IDLE;
                        irq_req_o <= 1'b0;
                    end else if (take) begin
                        // A better winner may replace an unanswered request.
                        irq_vector_o <= vect_q[win_line];
                        irq_line_o   <= win_line;
                    end
                end
                default: begin
                    hs_q      <= virq_pkg::VIRQ_IDLE;
                    irq_req_o <= 1'b0;
                end
            endcase
        end
    end
    // Active stack: entry ack pushes, exit ack retires the best-priority one.
    logic [4:0] top_line;
    always_comb begin
        top_line = 5'h00;
        for (int i = virq_pkg::NUM_LINES - 1; i >= 0; i--) begin
            if (active_q[i] && {1'b0, prio_q[i]} == run_prio) begin
                top_line = 5'(i);
            end
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_q <= 32'h0;
        end else begin
            if (ack_exit_i && run_prio != 3'h4) begin
                active_q[top_line] <= 1'b0;
            end
            if (ack_enter_i && hs_q == virq_pkg::VIRQ_REQ) begin
                active_q[irq_line_o] <= 1'b1;
            end
        end
    end
    // ----------------
    // Always-on wake logic
    // ----------------
    // Only wake-capable sources feed it; watchdog drops out in Hibernate.
    logic wake_hit;
    always_comb begin
        wake_hit = (|pin_hit & wake_en_q[0])
                 | (cmp_hit & wake_en_q[1])
                 | (wdog_hit_q & wake_en_q[2]
                    & (power_state_i != virq_pkg::PWR_HIBER));
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_req_o <= 1'b0;
        end else if (power_state_i == virq_pkg::PWR_ACTIVE) begin
            wake_req_o <= 1'b0;
        end else if (wake_hit) begin
            wake_req_o <= 1'b1;
        end
    end
    // ----------------
    // APB register writes
    // ----------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_q   <= 32'h0;
            wake_en_q  <= 32'h0;
            pin_edge_q <= 32'h0;
            wdog_ctl_q <= 32'h0;
            wdog_lim_q <= virq_pkg::RST_WDOG_LIM;
            i2c_en_q   <= 11'h000;
            for (int i = 0; i < virq_pkg::NUM_LINES; i++) begin
                prio_q[i] <= 2'h0;
                sel_q[i]  <= 6'(i + virq_pkg::SRC_FABRIC);
                vect_q[i] <= virq_pkg::RST_VECT;
            end
            // Lines zero and one default to the two port-pin sources.
            sel_q[0] <= virq_pkg::SRC_PORT0;
            sel_q[1] <= virq_pkg::SRC_PORT1;
        end else if (wr_en) begin
            if (paddr_i == virq_pkg::OFS_ENABLE) begin
                enable_q <= pwdata_i;
            end else if (paddr_i == virq_pkg::OFS_WAKE_EN) begin
                wake_en_q <= pwdata_i;
            end else if (paddr_i == virq_pkg::OFS_PIN_EDGE) begin
                pin_edge_q <= pwdata_i;
            end else if (paddr_i == virq_pkg::OFS_WDOG_CTL) begin
                wdog_ctl_q <= pwdata_i;
            end else if (paddr_i == virq_pkg::OFS_WDOG_LIM) begin
                wdog_lim_q <= pwdata_i;
            end else if (paddr_i == virq_pkg::OFS_I2C_EN) begin
                i2c_en_q <= pwdata_i[10:0];
            end else if (in_table(paddr_i, virq_pkg::OFS_PRIO, 8)) begin
                // Four lines per word, two bits each at the bottom of every byte lane.
                for (int k = 0; k < 4; k++) begin
                    prio_q[{paddr_i[4:2], 2'(k)}] <= pwdata_i[8*k +: 2];
                end
            end else if (in_table(paddr_i, virq_pkg::OFS_SEL, 8)) begin
                for (int k = 0; k < 4; k++) begin
                    sel_q[{paddr_i[4:2], 2'(k)}] <= pwdata_i[8*k +: 6];
                end
            end else if (in_table(paddr_i, virq_pkg::OFS_VECT, 32)) begin
                vect_q[paddr_i[6:2]] <= pwdata_i;
            end
        end
    end
    // ----------------
    // APB reads: zero wait states, registered data.
    // ----------------
    logic        bad_addr;
    logic [31:0] rd_val;
    always_comb begin
        rd_val   = 32'h0;
        bad_addr = 1'b0;
        if (paddr_i == virq_pkg::OFS_ENABLE) begin
            rd_val = enable_q;
        end else if (paddr_i == virq_pkg::OFS_PENDING) begin
            rd_val = pending_q;
        end else if (paddr_i == virq_pkg::OFS_ACTIVE) begin
            rd_val = active_q;
        end else if (paddr_i == virq_pkg::OFS_STATUS) begin
            rd_val = {21'h0, run_prio, wake_req_o, irq_req_o, 1'b0, irq_line_o};
        end else if (paddr_i == virq_pkg::OFS_WAKE_EN) begin
            rd_val = wake_en_q;
        end else if (paddr_i == virq_pkg::OFS_PIN_EDGE) begin
            rd_val = pin_edge_q;
        end else if (paddr_i == virq_pkg::OFS_PIN_FLAG) begin
            rd_val = {16'h0, pin_flag_q};
        end else if (paddr_i == virq_pkg::OFS_WDOG_CTL) begin
            rd_val = wdog_ctl_q;
        end else if (paddr_i == virq_pkg::OFS_WDOG_LIM) begin
            rd_val = wdog_lim_q;
        end else if (paddr_i == virq_pkg::OFS_I2C_EN) begin
            rd_val = {21'h0, i2c_en_q};
        end else if (in_table(paddr_i, virq_pkg::OFS_PRIO, 8)) begin
            for (int k = 0; k < 4; k++) begin
                rd_val[8*k +: 2] = prio_q[{paddr_i[4:2], 2'(k)}];
            end
        end else if (in_table(paddr_i, virq_pkg::OFS_SEL, 8)) begin
            for (int k = 0; k < 4; k++) begin
                rd_val[8*k +: 6] = sel_q[{paddr_i[4:2], 2'(k)}];
            end
        end else if (in_table(paddr_i, virq_pkg::OFS_VECT, 32)) begin
            rd_val = vect_q[paddr_i[6:2]];
        end else begin
            bad_addr = 1'b1;
        end
    end
    // Ready rises one cycle after setup, in the first access cycle, so data can be registered.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & bad_addr;
            prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_val : 32'h0;
        end
    end
endmodule

// ==== virq_ctrl_assertions.sv ====
// Purpose: Port-level protocol checks for the vectored interrupt controller.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes:   Attached to every controller instance by the bind at the foot.
module virq_ctrl_assertions (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    input  wire logic [1:0]  power_state_i,
    input  wire logic        irq_req_o,
    input  wire logic        ack_enter_i,
    input  wire logic        wake_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // A transfer is a setup cycle answered by a one-cycle ready pulse.
    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_answer; pready_o ##1 !pready_o; endsequence
    a_apb_answer: assert property (s_setup |=> s_answer)
        else $error("ready did not pulse once after setup");
    a_idle_data: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data not zero outside the answer");
    a_err_in_access: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
        else $error("error flag outside an access phase");
    a_req_holds: assert property (irq_req_o && !ack_enter_i |=> irq_req_o)
        else $error("request dropped before entry ack");
    a_req_drops: assert property (irq_req_o && ack_enter_i |=> !irq_req_o)
        else $error("request stayed after entry ack");
    a_wake_holds: assert property (wake_req_o && power_state_i != 2'h0 |=> wake_req_o)
        else $error("wake request dropped in low power");
    a_wake_quiet: assert property (!wake_req_o && power_state_i == 2'h0 |=> !wake_req_o)
        else $error("wake request raised while active");
    a_wake_cause: assert property ($rose(wake_req_o) |-> $past(power_state_i) != 2'h0)
        else $error("wake request without a low power state");
endmodule
bind virq_ctrl virq_ctrl_assertions i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .power_state_i(power_state_i), .irq_req_o(irq_req_o), .ack_enter_i(ack_enter_i),
    .wake_req_o(wake_req_o));

// ==== virq_core_model.sv ====
// Purpose: Behavioural processor core answering the interrupt hand-shake.
// Assumes: take_i lets the bench make the core slow; ret_i ends a routine.
// Notes:   Never acks twice in a row, as the request drops one edge later.
module virq_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       irq_req_i,
    input  wire logic [4:0] irq_line_i,
    input  wire logic       take_i,
    input  wire logic       ret_i,
    output logic            ack_enter_o,
    output logic            ack_exit_o,
    output logic [4:0]      last_line_o
);
    // Entry and exit acks are one-cycle pulses; the taken line is recorded.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_enter_o <= 1'b0;
            ack_exit_o  <= 1'b0;
            last_line_o <= 5'h00;
        end else begin
            ack_enter_o <= irq_req_i && take_i && !ack_enter_o;
            ack_exit_o  <= ret_i;
            if (irq_req_i && take_i && !ack_enter_o) last_line_o <= irq_line_i;
        end
    end
endmodule

// ==== vectored_irq_wake_controller_test.sv ====
// Purpose: Self-checking bench for the vectored interrupt and wake controller.
// Assumes: APB slave answers on its own; the core model acks on command.
// Notes:   Fabric lines 2 and 3 and port pin 0 carry the stimulus.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module vectored_irq_wake_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, take_i = 0, ret_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, fabric_src_i = 32'h0, prdata_o, irq_vector_o;
    logic [7:0] port0_pins_i = 8'h00;
    logic [1:0] power_state_i = 2'h0;
    logic [4:0] irq_line_o, last_line;
    logic pready_o, pslverr_o, irq_req_o, ack_enter_i, ack_exit_i, wake_req_o;
    int n_mismatch = 0, check_count = 0;
    virq_ctrl i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .port0_pins_i(port0_pins_i),
        .port1_pins_i(8'h00), .cmp_out_i(1'b0), .i2c_events_i(11'h000),
        .fabric_src_i(fabric_src_i), .power_state_i(power_state_i), .irq_req_o(irq_req_o),
        .irq_vector_o(irq_vector_o), .irq_line_o(irq_line_o), .ack_enter_i(ack_enter_i),
        .ack_exit_i(ack_exit_i), .wake_req_o(wake_req_o), .wdog_reset_o());
    virq_core_model i_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .irq_req_i(irq_req_o),
        .irq_line_i(irq_line_o), .take_i(take_i), .ret_i(ret_i), .ack_enter_o(ack_enter_i),
        .ack_exit_o(ack_exit_i), .last_line_o(last_line));
    // ----------------
    // Bus and hand-shake tasks
    // ----------------
    // One APB transfer; the idle edge at the end keeps drivers from clashing.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK("rdata", d, r)
        `CHK("slverr", err, e)
    endtask
    // Waits for a request, judges it, then lets the core enter the routine.
    task automatic take(input logic [4:0] l);
        int n = 0;
        do begin @(posedge clk_i); n++; end while (irq_req_o !== 1'b1 && n < 20);
        `CHK("line", l, irq_line_o)
        `CHK("vector", {24'h00000a, 3'h0, l}, irq_vector_o)
        take_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        take_i <= 1'b0;
        `CHK("taken", l, last_line)
    endtask
    task automatic ret;
        ret_i <= 1'b1;
        @(posedge clk_i);
        ret_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs;
        rd(virq_pkg::OFS_WDOG_LIM, virq_pkg::RST_WDOG_LIM, 1'b0);
        rd(12'hffc, 32'h0, 1'b1);
        wr(virq_pkg::OFS_VECT + 12'h07c, 32'h0000_0a1f);
        rd(virq_pkg::OFS_VECT + 12'h07c, 32'h0000_0a1f, 1'b0);
        $display("test regs done");
    endtask
    // Line 3 (priority 1) beats line 2 (priority 2); masking and nesting.
    task automatic t_nest;
        wr(virq_pkg::OFS_SEL, 32'h2322_0100);
        wr(virq_pkg::OFS_PRIO, 32'h0102_0000);
        wr(virq_pkg::OFS_VECT + 12'h008, 32'h0000_0a02);
        wr(virq_pkg::OFS_VECT + 12'h00c, 32'h0000_0a03);
        fabric_src_i <= 32'h0000_0004;
        repeat (4) @(posedge clk_i);
        `CHK("masked", 1'b0, irq_req_o)
        wr(virq_pkg::OFS_ENABLE, 32'h0000_000c);
        take(5'd2);
        fabric_src_i <= 32'h0000_000c;
        take(5'd3);
        fabric_src_i <= 32'h0;
        ret();
        ret();
        fabric_src_i <= 32'h0000_000c;
        take(5'd3);
        repeat (4) @(posedge clk_i);
        `CHK("no preempt", 1'b0, irq_req_o)
        ret();
        take(5'd2);
        ret();
        $display("test nest done");
    endtask
    task automatic pin_step(input logic v, input logic e, input logic [1:0] s);
        wr(virq_pkg::OFS_PIN_FLAG, 32'hffff_ffff);
        power_state_i <= s;
        port0_pins_i <= {7'h00, v};
        repeat (3) @(posedge clk_i);
        `CHK("wake", e, wake_req_o)
        power_state_i <= virq_pkg::PWR_ACTIVE;
        repeat (3) @(posedge clk_i);
        `CHK("wake off", 1'b0, wake_req_o)
    endtask
    // Every pin edge code, rising then falling, from two low-power states.
    task automatic t_wake;
        wr(virq_pkg::OFS_WAKE_EN, 32'h0000_0001);
        for (int c = 1; c < 4; c++) begin
            wr(virq_pkg::OFS_PIN_EDGE, 32'(c));
            pin_step(1'b1, c[0], virq_pkg::PWR_HIBER);
            pin_step(1'b0, c[1], virq_pkg::PWR_DEEP);
        end
        $display("test wake done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Clock, reset, main sequence and a watchdog far beyond the run length.
    initial begin forever #12.5 clk_i = ~clk_i; end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_nest();
        t_wake();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        end_of_test();
    end
endmodule
